// >>> can_err_pkg.sv
// constants and types for the can error status flag block
// How it works
// - receive error count is read-only, eight bits, zero after reset.
// - transmit error count is separate, read-only, eight bits, zero after reset.
// - bus-off flag sets when transmit error count reaches 255.
// - bus-off flag clears only after successful bus recovery.
// - transmit passive flag follows transmit count at or above 128.
// - receive passive flag follows receive count at or above 128.
// - transmit warning flag follows transmit count at or above 96.
// - receive warning flag follows receive count at or above 96.
// - combined warning is OR of transmit and receive warning.
// - top two flag bits read/write, lower six read-only, all reset zero.
package can_err_pkg;
    localparam logic [7:0] tec_addr = 8'h1c;
    localparam logic [7:0] rec_addr = 8'h1d;
    localparam logic [7:0] error_flags_addr = 8'h2d;
    localparam logic [7:0] count_reset = 8'h00;
    localparam logic [7:0] flags_reset = 8'h00;
    localparam logic [7:0] read_unmapped = 8'h00;
    localparam logic [7:0] bus_off_level = 8'hff;
    localparam logic [7:0] passive_level = 8'h80;
    localparam logic [7:0] warning_level = 8'h60;
    localparam int bit_buf1_ovr = 7;
    localparam int bit_buf0_ovr = 6;
    localparam int bit_bus_off = 5;
    localparam int bit_tx_passive = 4;
    localparam int bit_rx_passive = 3;
    localparam int bit_tx_warning = 2;
    localparam int bit_rx_warning = 1;
    localparam int bit_any_warning = 0;

    // count updates from the protocol engine
    typedef struct packed {
        logic tec_we;
        logic [7:0] transmit_error_count;
        logic rec_we;
        logic [7:0] rec;
    } count_update_type;

    // host register access port
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_type;
endpackage

// >>> can_error_status_flags.sv
// error counters and error flag register of the can controller
`timescale 1ns/1ps
`default_nettype none
module can_error_status_flags (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire can_err_pkg::reg_access_type host_i,
    input wire can_err_pkg::count_update_type count_upd_i,
    input wire logic [1:0] rx_msg_valid_i,
    input wire logic [1:0] rx_buf_full_irq_i,
    input wire logic recovery_done_i,
    output logic [7:0] rd_data_o,
    output logic [7:0] transmit_error_count_o,
    output logic [7:0] receive_error_count_o,
    output logic [7:0] error_flags_o
);
    import can_err_pkg::*;

    // counters, loaded by the protocol engine only
    logic [7:0] tec_reg;
    logic [7:0] tec_next;
    logic [7:0] rec_reg;
    logic [7:0] rec_next;

    // error flag register and its per-field next values
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic host_flags_wr;
    logic [1:0] ovr_cur;
    logic [1:0] ovr_new;
    logic bus_off_new;
    logic tx_passive_new;
    logic rx_passive_new;
    logic tx_warning_new;
    logic rx_warning_new;
    logic any_warning_new;

    // host read data
    logic [7:0] rd_reg;
    logic [7:0] rd_next;

    // counter group
    always_comb begin
        tec_next = tec_reg;
        rec_next = rec_reg;
        if (count_upd_i.tec_we) begin
            tec_next = count_upd_i.transmit_error_count;
        end
        if (count_upd_i.rec_we) begin
            rec_next = count_upd_i.rec;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tec_reg <= count_reset;
            rec_reg <= count_reset;
        end else begin
            tec_reg <= tec_next;
            rec_reg <= rec_next;
        end
    end

    // flag group: host write strobe and current overflow bits
    always_comb begin
        host_flags_wr = host_i.wr && (host_i.addr == error_flags_addr);
        ovr_cur = flags_reg[bit_buf1_ovr:bit_buf0_ovr];
    end

    // one overflow flag per receive buffer; a hardware set wins over a host clear
    for (genvar n = 0; n < $bits(ovr_new); n++) begin : gen_ovr
        always_comb begin
            ovr_new[n] = ovr_cur[n];
            if (host_flags_wr) begin
                ovr_new[n] = host_i.wdata[bit_buf0_ovr + n];
            end
            if (rx_msg_valid_i[n] && rx_buf_full_irq_i[n]) begin
                ovr_new[n] = 1'b1;
            end
        end
    end

    // bus-off: the maximum count wins over a same-cycle recovery
    always_comb begin
        bus_off_new = flags_reg[bit_bus_off];
        if (recovery_done_i) begin
            bus_off_new = 1'b0;
        end
        if (tec_next == bus_off_level) begin
            bus_off_new = 1'b1;
        end
    end

    // threshold flags follow the counts that load on the same edge
    always_comb begin
        tx_passive_new = (tec_next >= passive_level);
        rx_passive_new = (rec_next >= passive_level);
        tx_warning_new = (tec_next >= warning_level);
        rx_warning_new = (rec_next >= warning_level);
        any_warning_new = tx_warning_new || rx_warning_new;
    end

    always_comb begin
        flags_next = flags_reset;
        flags_next[bit_buf1_ovr:bit_buf0_ovr] = ovr_new;
        flags_next[bit_bus_off] = bus_off_new;
        flags_next[bit_tx_passive] = tx_passive_new;
        flags_next[bit_rx_passive] = rx_passive_new;
        flags_next[bit_tx_warning] = tx_warning_new;
        flags_next[bit_rx_warning] = rx_warning_new;
        flags_next[bit_any_warning] = any_warning_new;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_reg <= flags_reset;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // read group: data registered one cycle after the address
    always_comb begin
        unique case (host_i.addr)
            tec_addr: rd_next = tec_reg;
            rec_addr: rd_next = rec_reg;
            error_flags_addr: rd_next = flags_reg;
            default: rd_next = read_unmapped;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_reg <= read_unmapped;
        end else begin
            rd_reg <= rd_next;
        end
    end

    // outputs straight from the registers
    assign rd_data_o = rd_reg;
    assign transmit_error_count_o = tec_reg;
    assign receive_error_count_o = rec_reg;
    assign error_flags_o = flags_reg;

    chk_rec_host_ro: assert property (@(posedge clk_i) disable iff (rst_i)
        !count_upd_i.rec_we |=> $stable(rec_reg))
        else $error("receive count changed without engine update");
    chk_tec_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        count_upd_i.tec_we |=> tec_reg == $past(count_upd_i.transmit_error_count))
        else $error("transmit count did not take update");
    chk_ovr_set: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_msg_valid_i[0] && rx_buf_full_irq_i[0] |=> flags_reg[bit_buf0_ovr])
        else $error("buffer 0 overflow not flagged");
    chk_ovr_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_buf1_ovr] && !(host_i.wr && host_i.addr == error_flags_addr)
        |=> flags_reg[bit_buf1_ovr])
        else $error("buffer 1 overflow cleared without host write");
    chk_bus_off_set: assert property (@(posedge clk_i) disable iff (rst_i)
        tec_reg == bus_off_level |-> flags_reg[bit_bus_off])
        else $error("bus-off flag missing at maximum count");
    chk_bus_off_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(flags_reg[bit_bus_off]) |-> $past(recovery_done_i))
        else $error("bus-off cleared without recovery");
    chk_tx_passive: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_tx_passive] == (tec_reg >= passive_level))
        else $error("transmit passive flag wrong");
    chk_rx_passive: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_rx_passive] == (rec_reg >= passive_level))
        else $error("receive passive flag wrong");
    chk_tx_warning: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_tx_warning] == (tec_reg >= warning_level))
        else $error("transmit warning flag wrong");
    chk_rx_warning: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_rx_warning] == (rec_reg >= warning_level))
        else $error("receive warning flag wrong");
    chk_any_warning: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_any_warning] == (flags_reg[bit_tx_warning] || flags_reg[bit_rx_warning]))
        else $error("combined warning flag wrong");
    chk_flags_ro: assert property (@(posedge clk_i) disable iff (rst_i)
        host_i.wr && host_i.addr == error_flags_addr && !count_upd_i.tec_we && !count_upd_i.rec_we
        && !recovery_done_i |=> flags_reg[5:0] == $past(flags_reg[5:0]))
        else $error("host write changed read-only flags");

    // overflow flags
    chk_ovr1_set: assert property (@(posedge clk_i) disable iff (rst_i)
        rx_msg_valid_i[1] && rx_buf_full_irq_i[1] |=> flags_reg[bit_buf1_ovr])
        else $error("buffer 1 overflow not flagged");

    chk_ovr0_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_buf0_ovr] && !host_flags_wr |=> flags_reg[bit_buf0_ovr])
        else $error("buffer 0 overflow cleared without host write");

    chk_ovr0_host_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        host_flags_wr && !host_i.wdata[bit_buf0_ovr] && !(rx_msg_valid_i[0]
        && rx_buf_full_irq_i[0]) |=> !flags_reg[bit_buf0_ovr])
        else $error("buffer 0 overflow not cleared by host");

    chk_ovr1_host_clr: assert property (@(posedge clk_i) disable iff (rst_i)
        host_flags_wr && !host_i.wdata[bit_buf1_ovr] && !(rx_msg_valid_i[1]
        && rx_buf_full_irq_i[1]) |=> !flags_reg[bit_buf1_ovr])
        else $error("buffer 1 overflow not cleared by host");

    chk_ovr0_host_set: assert property (@(posedge clk_i) disable iff (rst_i)
        host_flags_wr && host_i.wdata[bit_buf0_ovr] |=> flags_reg[bit_buf0_ovr])
        else $error("buffer 0 overflow not writable");

    chk_ovr1_host_set: assert property (@(posedge clk_i) disable iff (rst_i)
        host_flags_wr && host_i.wdata[bit_buf1_ovr] |=> flags_reg[bit_buf1_ovr])
        else $error("buffer 1 overflow not writable");

    chk_ovr0_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !flags_reg[bit_buf0_ovr] && !(host_flags_wr && host_i.wdata[bit_buf0_ovr])
        && !(rx_msg_valid_i[0] && rx_buf_full_irq_i[0]) |=> !flags_reg[bit_buf0_ovr])
        else $error("buffer 0 overflow set without cause");

    chk_ovr1_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        !flags_reg[bit_buf1_ovr] && !(host_flags_wr && host_i.wdata[bit_buf1_ovr])
        && !(rx_msg_valid_i[1] && rx_buf_full_irq_i[1]) |=> !flags_reg[bit_buf1_ovr])
        else $error("buffer 1 overflow set without cause");

    chk_ovr0_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        host_flags_wr && rx_msg_valid_i[0] && rx_buf_full_irq_i[0] |=> flags_reg[bit_buf0_ovr])
        else $error("host clear beat buffer 0 overflow set");

    chk_ovr1_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
        host_flags_wr && rx_msg_valid_i[1] && rx_buf_full_irq_i[1] |=> flags_reg[bit_buf1_ovr])
        else $error("host clear beat buffer 1 overflow set");

    // bus-off flag
    chk_bus_off_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_bus_off] && !recovery_done_i |=> flags_reg[bit_bus_off])
        else $error("bus-off dropped without recovery");

    chk_bus_off_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_bus_off] && recovery_done_i
        && (count_upd_i.tec_we ? count_upd_i.transmit_error_count != bus_off_level : tec_reg != bus_off_level)
        |=> !flags_reg[bit_bus_off])
        else $error("bus-off not cleared by recovery");

    chk_bus_off_rise: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(flags_reg[bit_bus_off]) |-> tec_reg == bus_off_level)
        else $error("bus-off set below maximum count");

    chk_bus_off_load: assert property (@(posedge clk_i) disable iff (rst_i)
        count_upd_i.tec_we && count_upd_i.transmit_error_count == bus_off_level |=> flags_reg[bit_bus_off])
        else $error("bus-off not set on maximum load");

    // counters
    chk_rec_update: assert property (@(posedge clk_i) disable iff (rst_i)
        count_upd_i.rec_we |=> rec_reg == $past(count_upd_i.rec))
        else $error("receive count did not take update");

    chk_tec_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        !count_upd_i.tec_we |=> $stable(tec_reg))
        else $error("transmit count changed without engine update");

    chk_rec_host_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        host_i.wr && host_i.addr == rec_addr && !count_upd_i.rec_we |=> $stable(rec_reg))
        else $error("host write changed receive count");

    chk_tec_host_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        host_i.wr && host_i.addr == tec_addr && !count_upd_i.tec_we |=> $stable(tec_reg))
        else $error("host write changed transmit count");

    // read port
    chk_rd_tec: assert property (@(posedge clk_i) disable iff (rst_i)
        host_i.addr == tec_addr |=> rd_data_o == $past(tec_reg))
        else $error("transmit count read wrong");

    chk_rd_rec: assert property (@(posedge clk_i) disable iff (rst_i)
        host_i.addr == rec_addr |=> rd_data_o == $past(rec_reg))
        else $error("receive count read wrong");

    chk_rd_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        host_i.addr == error_flags_addr |=> rd_data_o == $past(flags_reg))
        else $error("flag register read wrong");

    chk_rd_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        host_i.addr != tec_addr && host_i.addr != rec_addr && host_i.addr != error_flags_addr
        |=> rd_data_o == read_unmapped)
        else $error("unmapped read not zero");

    // threshold flags
    chk_any_counts: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_any_warning] == (tec_reg >= warning_level || rec_reg >= warning_level))
        else $error("combined warning does not match counts");

    chk_tx_pass_warn: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_tx_passive] |-> flags_reg[bit_tx_warning])
        else $error("transmit passive without warning");

    chk_rx_pass_warn: assert property (@(posedge clk_i) disable iff (rst_i)
        flags_reg[bit_rx_passive] |-> flags_reg[bit_rx_warning])
        else $error("receive passive without warning");

    chk_tx_passive_load: assert property (@(posedge clk_i) disable iff (rst_i)
        count_upd_i.tec_we |=> flags_reg[bit_tx_passive] == ($past(count_upd_i.transmit_error_count) >= passive_level))
        else $error("transmit passive wrong after load");

    chk_rx_passive_load: assert property (@(posedge clk_i) disable iff (rst_i)
        count_upd_i.rec_we |=> flags_reg[bit_rx_passive] == ($past(count_upd_i.rec) >= passive_level))
        else $error("receive passive wrong after load");

    chk_tx_warning_load: assert property (@(posedge clk_i) disable iff (rst_i)
        count_upd_i.tec_we |=> flags_reg[bit_tx_warning] == ($past(count_upd_i.transmit_error_count) >= warning_level))
        else $error("transmit warning wrong after load");

    chk_rx_warning_load: assert property (@(posedge clk_i) disable iff (rst_i)
        count_upd_i.rec_we |=> flags_reg[bit_rx_warning] == ($past(count_upd_i.rec) >= warning_level))
        else $error("receive warning wrong after load");

    chk_any_load: assert property (@(posedge clk_i) disable iff (rst_i)
        count_upd_i.tec_we && count_upd_i.rec_we |=> flags_reg[bit_any_warning]
        == ($past(count_upd_i.transmit_error_count) >= warning_level || $past(count_upd_i.rec) >= warning_level))
        else $error("combined warning wrong after load");

endmodule // can_error_status_flags
`default_nettype wire

// >>> can_host_model.sv
// host side model that issues register accesses
`timescale 1ns/1ps
`default_nettype none
module can_host_model (
    input wire logic wr_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output var can_err_pkg::reg_access_type host_o
);
    import can_err_pkg::*;
    // overflow clears are plain writes of zero from here
    assign host_o = '{wr_i, addr_i, wdata_i};
endmodule // can_host_model
`default_nettype wire

// >>> can_error_status_flags_test.sv
// testbench for the can error status flag block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module can_error_status_flags_test;
    import can_err_pkg::*;
    logic clk_i = 0, rst_i = 1, wr = 0, rdone = 0, bo = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rd_data, tec_o, rec_o, flags, t, r;
    logic [1:0] vld = 2'b00, full = 2'b00;
    reg_access_type host;
    count_update_type upd = '0;
    logic [31:0] seed = 32'h97b3_05d4;
    int error_cnt = 0, n_tests = 0;
    logic [7:0] corner [6] = '{8'h5f, 8'h60, 8'h7f, 8'h80, 8'hfe, 8'hff};
    can_host_model HOST (.wr_i(wr), .addr_i(addr), .wdata_i(wdata), .host_o(host));
    can_error_status_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .host_i(host),
        .count_upd_i(upd), .rx_msg_valid_i(vld), .rx_buf_full_irq_i(full),
        .recovery_done_i(rdone), .rd_data_o(rd_data), .transmit_error_count_o(tec_o),
        .receive_error_count_o(rec_o), .error_flags_o(flags));
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [4:0] lowf(input logic [7:0] a, input logic [7:0] b);
        return {a >= 8'h80, b >= 8'h80, a >= 8'h60, b >= 8'h60, a >= 8'h60 || b >= 8'h60};
    endfunction
    task automatic ld(input logic [7:0] a, input logic [7:0] b, input logic d);
        upd = '{1'b1, a, 1'b1, b};
        rdone = d;
        bo = (a == bus_off_level) ? 1'b1 : (d ? 1'b0 : bo);
        @(negedge clk_i);
        upd = '0;
        rdone = 1'b0;
        @(negedge clk_i);
        `CHK(tec_o, a)
        `CHK(rec_o, b)
        `CHK(flags[4:0], lowf(a, b))
        `CHK(flags[5], bo)
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        @(negedge clk_i);
        `CHK(rd_data, e)
    endtask
    task automatic wrt(input logic [7:0] a, input logic [7:0] d);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_i);
        wr = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 0;
        `CHK(flags, flags_reset)
        for (int i = 0; i < 80; i++) begin
            seed = xs(seed);
            t = (i < 6) ? corner[i] : seed[7:0];
            r = (i < 6) ? corner[5 - i] : seed[15:8];
            ld(t, r, seed[16] & seed[17]);
        end
        ld(bus_off_level, 8'h10, 1'b1);
        ld(8'h00, 8'h10, 1'b0);
        ld(8'h00, 8'h10, 1'b1);
        wrt(rec_addr, 8'h55);
        wrt(tec_addr, 8'h55);
        rd(rec_addr, 8'h10);
        rd(tec_addr, 8'h00);
        wrt(error_flags_addr, 8'hff);
        rd(error_flags_addr, 8'hc0);
        wrt(error_flags_addr, 8'h00);
        `CHK(flags[7:6], 2'b00)
        vld = 2'b11;
        full = 2'b01;
        @(negedge clk_i);
        vld = 2'b00;
        repeat (3) @(negedge clk_i);
        `CHK(flags[7:6], 2'b01)
        vld = 2'b10;
        full = 2'b10;
        @(negedge clk_i);
        vld = 2'b00;
        @(negedge clk_i);
        `CHK(flags[7:6], 2'b11)
        vld = 2'b01;
        full = 2'b01;
        wr = 1'b1;
        addr = error_flags_addr;
        wdata = 8'h00;
        @(negedge clk_i);
        vld = 2'b00;
        wr = 1'b0;
        @(negedge clk_i);
        `CHK(flags[7:6], 2'b01)
        rd(8'h00, read_unmapped);
        finish_test();
    end
endmodule // can_error_status_flags_test
`default_nettype wire
